// ---- burst_sram_port.sv ----
// Pipelined burst static memory port with an APB status and control slave.
// Assumes all pins are synchronous to i_core_clk and the bus wire is resolved outside.
`include "burst_sram_defines.svh"
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Address, control and write data are taken into registers at the rising clock edge.
// - Read data leaves the port from registers that update on the rising clock edge.
// - With the clock qualifier high an edge is ignored and every memory-side state and the read data hold; the APB registers still update.
// - Reads and writes follow each other in any order on every cycle with no wait.
// - A write updates only the byte lanes whose low-active lane select is asserted.
// - Each write completes inside the port at one edge with no external pulse timing.
// - A new access is taken only when the two low-active selects and the high select all agree.
// - The data drivers are off, synchronously, in the data cycle of every write.
// - The low-active output enable turns the drivers off at once, without the clock.
// - Bursts step linearly with the order strap low and interleaved with it high.
// - A sleep input parks the port while the stored contents are kept.
module burst_sram_port (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [`SRAM_ADDR_W-1:0] i_addr,
	input wire logic i_burst_advance_or_load,
	input wire logic i_write_n,
	input wire logic [`SRAM_LANES-1:0] i_byte_lane_write_n,
	input wire logic i_chip_select_first_n,
	input wire logic i_chip_select_second,
	input wire logic i_chip_select_third_n,
	input wire logic i_clock_qualify_n,
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	input wire logic i_burst_order_interleave,
	input wire logic [`SRAM_DATA_W-1:0] i_dq,
	output logic [`SRAM_DATA_W-1:0] o_dq,
	output logic o_dq_oe,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [`APB_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);

	// Address stage: command captured at the edge that took the address.
	burst_sram_pkg::cmd_t a_cmd;
	burst_sram_pkg::cmd_t next_a_cmd;
	logic [`SRAM_ADDR_W-1:0] a_addr;
	logic [`SRAM_ADDR_W-1:0] next_a_addr;
	logic [`SRAM_LANES-1:0] a_lanes;
	logic [`SRAM_LANES-1:0] next_a_lanes;

	// Data stage: command one edge older, acted on at the next edge.
	burst_sram_pkg::cmd_t b_cmd;
	burst_sram_pkg::cmd_t next_b_cmd;
	logic [`SRAM_ADDR_W-1:0] b_addr;
	logic [`SRAM_ADDR_W-1:0] next_b_addr;
	logic [`SRAM_LANES-1:0] b_lanes;
	logic [`SRAM_LANES-1:0] next_b_lanes;

	// Synchronous half of the data driver enable.
	logic drive;
	logic next_drive;

	// Power state.
	burst_sram_pkg::power_state_t power_state;
	burst_sram_pkg::power_state_t next_power_state;

	// Register bus state.
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [31:0] prdata;
	logic [31:0] next_prdata;
	logic pready;
	logic next_pready;
	logic pslverr;
	logic next_pslverr;

	// Combinational helpers.
	logic qualified;
	logic selected;
	logic load;
	logic asleep;
	logic [`SRAM_ADDR_W-1:0] burst_addr;
	logic [`SRAM_BURST_W-1:0] burst_count;
	logic [31:0] status;
	logic hit_ctrl;
	logic hit_status;

	assign qualified = !i_clock_qualify_n;
	assign selected = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
	assign load = !i_burst_advance_or_load;
	assign asleep = (power_state == burst_sram_pkg::PWR_ASLEEP);

	burst_addr_gen u_burst (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_step(qualified && !asleep),
		.i_load(load),
		.i_interleave(i_burst_order_interleave),
		.i_addr(i_addr),
		.o_addr(burst_addr),
		.o_count(burst_count)
	);

	// Read launched at the first edge after the address so that it stands at the second.
	// Write data is taken at the second edge, so read and write data cycles never overlap.
	sram_lane_array u_array (
		.i_core_clk(i_core_clk),
		.i_nrst(i_nrst),
		.i_enable(qualified),
		.i_read(a_cmd == burst_sram_pkg::CMD_READ),
		.i_write(b_cmd == burst_sram_pkg::CMD_WRITE),
		.i_lane_write(b_lanes),
		.i_raddr(a_addr),
		.i_addr(b_addr),
		.i_wdata(i_dq),
		.o_rdata(o_dq)
	);

	// Power state follows the pin or the software request.
	always_comb begin
		next_power_state = power_state;
		if (qualified) begin
			case (power_state)
				burst_sram_pkg::PWR_AWAKE: begin
					if (i_sleep_request || ctrl[`CTRL_SLEEP_BIT]) begin
						next_power_state = burst_sram_pkg::PWR_ASLEEP;
					end
				end
				burst_sram_pkg::PWR_ASLEEP: begin
					if (!i_sleep_request && !ctrl[`CTRL_SLEEP_BIT]) begin
						next_power_state = burst_sram_pkg::PWR_AWAKE;
					end
				end
				default: begin
					next_power_state = burst_sram_pkg::PWR_AWAKE;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			power_state <= burst_sram_pkg::PWR_AWAKE;
		end else begin
			power_state <= next_power_state;
		end
	end

	// Access pipeline; every stage holds while the clock qualifier is high.
	always_comb begin
		next_a_cmd = a_cmd;
		next_a_addr = a_addr;
		next_a_lanes = a_lanes;
		next_b_cmd = b_cmd;
		next_b_addr = b_addr;
		next_b_lanes = b_lanes;
		next_drive = drive;
		if (qualified) begin
			next_a_addr = burst_addr;
			next_a_lanes = ~i_byte_lane_write_n;
			if (asleep) begin
				next_a_cmd = burst_sram_pkg::CMD_IDLE;
			end else if (load && !selected) begin
				next_a_cmd = burst_sram_pkg::CMD_IDLE;
			end else if (load && i_write_n) begin
				next_a_cmd = burst_sram_pkg::CMD_READ;
			end else if (load) begin
				next_a_cmd = burst_sram_pkg::CMD_WRITE;
			end
			// Any command may follow any other on the next edge.
			next_b_cmd = a_cmd;
			next_b_addr = a_addr;
			next_b_lanes = a_lanes;
			next_drive = (a_cmd == burst_sram_pkg::CMD_READ);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			a_cmd <= burst_sram_pkg::CMD_IDLE;
			a_addr <= '0;
			a_lanes <= '0;
			b_cmd <= burst_sram_pkg::CMD_IDLE;
			b_addr <= '0;
			b_lanes <= '0;
			drive <= 1'b0;
		end else begin
			a_cmd <= next_a_cmd;
			a_addr <= next_a_addr;
			a_lanes <= next_a_lanes;
			b_cmd <= next_b_cmd;
			b_addr <= next_b_addr;
			b_lanes <= next_b_lanes;
			drive <= next_drive;
		end
	end

	// The output enable acts without the clock; the rest of the enable is registered.
	assign o_dq_oe = drive && !i_output_enable_n;

	// Status word gathered from the port's own state.
	always_comb begin
		status = 32'h0000_0000;
		status[`STAT_ASLEEP_BIT] = asleep;
		status[`STAT_INTERLEAVE_BIT] = i_burst_order_interleave;
		status[`STAT_DRIVE_BIT] = drive;
		status[`STAT_READ_PEND_BIT] = (a_cmd == burst_sram_pkg::CMD_READ) || (b_cmd == burst_sram_pkg::CMD_READ);
		status[`STAT_WRITE_PEND_BIT] = (a_cmd == burst_sram_pkg::CMD_WRITE) || (b_cmd == burst_sram_pkg::CMD_WRITE);
		status[`STAT_COUNT_LSB +: `SRAM_BURST_W] = burst_count;
	end

	// APB slave: one wait state, ready raised in the second access cycle.
	assign hit_ctrl = (i_paddr == `REG_CTRL_OFS);
	assign hit_status = (i_paddr == `REG_STATUS_OFS);

	always_comb begin
		next_ctrl = ctrl;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (i_psel && i_penable && !pready) begin
			next_pready = 1'b1;
			next_pslverr = !(hit_ctrl || hit_status);
			if (hit_ctrl) begin
				next_prdata = ctrl;
			end else if (hit_status) begin
				next_prdata = status;
			end else begin
				next_prdata = 32'h0000_0000;
			end
		end
		if (i_psel && i_penable && pready && i_pwrite && hit_ctrl) begin
			next_ctrl = 32'h0000_0000;
			next_ctrl[`CTRL_SLEEP_BIT] = i_pwdata[`CTRL_SLEEP_BIT];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl <= `CTRL_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	assign o_prdata = prdata;
	assign o_pready = pready;
	assign o_pslverr = pslverr;

endmodule : burst_sram_port

`default_nettype wire

// ---- burst_sram_defines.svh ----
// Constants for the pipelined burst static memory port.
// Assumes inclusion by its bare name from each file that needs it.
`ifndef BURST_SRAM_DEFINES_SVH
`define BURST_SRAM_DEFINES_SVH

// Word layout: four byte lanes of eight data bits and one parity bit.
`define SRAM_ADDR_W 18
`define SRAM_DEPTH 262144
`define SRAM_LANES 4
`define SRAM_LANE_W 9
`define SRAM_DATA_W 36
`define SRAM_BURST_W 2

// Register bus layout, byte addresses.
`define APB_ADDR_W 12
`define REG_CTRL_OFS 12'h000
`define REG_STATUS_OFS 12'h004

// Control register fields.
`define CTRL_SLEEP_BIT 0
`define CTRL_RESET 32'h0000_0000

// Status register fields.
`define STAT_ASLEEP_BIT 0
`define STAT_INTERLEAVE_BIT 1
`define STAT_DRIVE_BIT 2
`define STAT_READ_PEND_BIT 3
`define STAT_WRITE_PEND_BIT 4
`define STAT_COUNT_LSB 8

`endif

// ---- burst_sram_pkg.sv ----
// Types shared by the pipelined burst static memory port.
// Assumes no other package.
package burst_sram_pkg;

	// Operation held in each stage of the access pipeline.
	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_READ = 2'b01,
		CMD_WRITE = 2'b10
	} cmd_t;

	// Power state of the port.
	typedef enum logic [0:0] {
		PWR_AWAKE = 1'b0,
		PWR_ASLEEP = 1'b1
	} power_state_t;

endpackage : burst_sram_pkg

// ---- burst_addr_gen.sv ----
// Burst address generator: loads a start address and steps its two low bits.
// Assumes its step strobe is already qualified by the port's clock qualifier.
`include "burst_sram_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module burst_addr_gen (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_step,
	input wire logic i_load,
	input wire logic i_interleave,
	input wire logic [`SRAM_ADDR_W-1:0] i_addr,
	output logic [`SRAM_ADDR_W-1:0] o_addr,
	output logic [`SRAM_BURST_W-1:0] o_count
);

	logic [`SRAM_ADDR_W-1:0] base;
	logic [`SRAM_ADDR_W-1:0] next_base;
	logic [`SRAM_BURST_W-1:0] count;
	logic [`SRAM_BURST_W-1:0] next_count;
	logic [`SRAM_BURST_W-1:0] low;

	always_comb begin
		next_base = base;
		next_count = count;
		if (i_step && i_load) begin
			next_base = i_addr;
			next_count = '0;
		end else if (i_step) begin
			next_count = count + 2'h1;
		end
		// Linear order adds the count; interleaved order exclusive-ors it.
		if (i_interleave) begin
			low = base[`SRAM_BURST_W-1:0] ^ next_count;
		end else begin
			low = base[`SRAM_BURST_W-1:0] + next_count;
		end
		if (i_load) begin
			o_addr = i_addr;
		end else begin
			o_addr = {base[`SRAM_ADDR_W-1:`SRAM_BURST_W], low};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			base <= '0;
			count <= '0;
		end else begin
			base <= next_base;
			count <= next_count;
		end
	end

	assign o_count = count;

endmodule : burst_addr_gen

`default_nettype wire

// ---- sram_lane_array.sv ----
// Storage array with per-lane write and a registered read port.
// Assumes at most one read and one write per enabled edge; contents have no reset.
`include "burst_sram_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module sram_lane_array (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_enable,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [`SRAM_LANES-1:0] i_lane_write,
	input wire logic [`SRAM_ADDR_W-1:0] i_raddr,
	input wire logic [`SRAM_ADDR_W-1:0] i_addr,
	input wire logic [`SRAM_DATA_W-1:0] i_wdata,
	output logic [`SRAM_DATA_W-1:0] o_rdata
);

	genvar lane;
	generate
		for (lane = 0; lane < `SRAM_LANES; lane = lane + 1) begin : g_lane
			logic [`SRAM_LANE_W-1:0] lane_mem [0:`SRAM_DEPTH-1];
			logic [`SRAM_LANE_W-1:0] rdata;
			logic [`SRAM_LANE_W-1:0] next_rdata;

			always_comb begin
				next_rdata = rdata;
				if (i_enable && i_read) begin
					next_rdata = lane_mem[i_raddr];
					// A write landing at the same edge and address is passed straight through.
					if (i_write && i_lane_write[lane] && (i_raddr == i_addr)) begin
						next_rdata = i_wdata[lane*`SRAM_LANE_W +: `SRAM_LANE_W];
					end
				end
			end

			// Self-timed write: the whole write completes at one enabled edge.
			always_ff @(posedge i_core_clk) begin
				if (i_enable && i_write && i_lane_write[lane]) begin
					lane_mem[i_addr] <= i_wdata[lane*`SRAM_LANE_W +: `SRAM_LANE_W];
				end
			end

			always_ff @(posedge i_core_clk or negedge i_nrst) begin
				if (!i_nrst) begin
					rdata <= '0;
				end else begin
					rdata <= next_rdata;
				end
			end

			assign o_rdata[lane*`SRAM_LANE_W +: `SRAM_LANE_W] = rdata;
		end
	endgenerate

endmodule : sram_lane_array

`default_nettype wire

// ---- burst_sram_port_checker.sv ----
// Checker for the burst memory port: data driver timing and register bus answer.
// Assumes it is bound to burst_sram_port and sees only its ports.
`include "burst_sram_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_checker (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_burst_advance_or_load,
	input wire logic i_write_n,
	input wire logic i_chip_select_first_n,
	input wire logic i_chip_select_second,
	input wire logic i_chip_select_third_n,
	input wire logic i_clock_qualify_n,
	input wire logic i_output_enable_n,
	input wire logic i_sleep_request,
	input wire logic [`SRAM_DATA_W-1:0] o_dq,
	input wire logic o_dq_oe,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic o_pready,
	input wire logic o_pslverr
);
	wire ld = !i_clock_qualify_n && !i_burst_advance_or_load;
	wire sel = !i_chip_select_first_n && i_chip_select_second && !i_chip_select_third_n;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	AST_READ_DRIVE:
	assert property (ld && sel && i_write_n && !i_sleep_request && !$past(i_sleep_request)
		##1 !i_clock_qualify_n [*2] |-> o_dq_oe == !i_output_enable_n) else $error("read not driven");
	AST_WRITE_FLOAT:
	assert property (ld && sel && !i_write_n ##1 !i_clock_qualify_n [*2] |-> !o_dq_oe)
		else $error("driven in write data cycle");
	AST_DESELECT:
	assert property (ld && !sel ##1 !i_clock_qualify_n [*2] |-> !o_dq_oe) else $error("deselected drive");
	AST_SLEEP_IDLE:
	assert property (ld && i_sleep_request && $past(i_sleep_request) ##1 !i_clock_qualify_n [*2] |-> !o_dq_oe)
		else $error("drive while asleep");
	AST_OE_ASYNC:
	assert property (i_output_enable_n |-> !o_dq_oe) else $error("drive with enable off");
	AST_STALL_DATA:
	assert property (i_clock_qualify_n |=> $stable(o_dq)) else $error("data moved in stall");
	AST_STALL_DRIVE:
	assert property (i_clock_qualify_n ##1 $stable(i_output_enable_n) |-> $stable(o_dq_oe))
		else $error("drive moved in stall");
	AST_PREADY:
	assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("no ready");
	AST_PSLVERR:
	assert property (o_pslverr |-> o_pready ##1 !o_pready) else $error("error without ready pulse");
endmodule : burst_sram_port_checker
bind burst_sram_port burst_sram_port_checker burst_sram_port_checker_i (.i_core_clk, .i_nrst,
	.i_burst_advance_or_load, .i_write_n, .i_chip_select_first_n, .i_chip_select_second,
	.i_chip_select_third_n, .i_clock_qualify_n, .i_output_enable_n, .i_sleep_request, .o_dq, .o_dq_oe,
	.i_psel, .i_penable, .o_pready, .o_pslverr);
`default_nettype wire

// ---- mem_ctrl_model.sv ----
// Memory controller model: drives the port's pins and its side of the data bus.
// Assumes one call of cyc per clock, right after a rising edge.
`include "burst_sram_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
	input wire logic i_clk,
	input wire logic [`SRAM_DATA_W-1:0] i_port_dq,
	input wire logic i_port_oe,
	output logic [`SRAM_ADDR_W-1:0] o_addr,
	output logic o_adv,
	output logic o_write_n,
	output logic [`SRAM_LANES-1:0] o_lane_n,
	output logic [2:0] o_cs,
	output logic o_cq_n,
	output logic [`SRAM_DATA_W-1:0] o_bus,
	output logic [1:0] o_kind,
	output logic [`SRAM_DATA_W-1:0] o_exp
);
	logic [1:0] k1 = 2'h0;
	logic [1:0] kn = 2'h0;
	logic [`SRAM_DATA_W-1:0] d1;
	logic [`SRAM_DATA_W-1:0] dn;
	logic [`SRAM_DATA_W-1:0] last = 36'h0;
	initial begin
		o_kind = 2'h0;
		o_cq_n = 1'h0;
		o_adv = 1'h1;
		o_write_n = 1'h1;
		o_lane_n = 4'hF;
		o_cs = 3'h2;
		o_addr = 18'h0;
	end
	task automatic cyc(input logic v, input logic w, input logic [`SRAM_ADDR_W-1:0] a, input logic [3:0] l,
		input logic [2:0] c, input logic q, input logic [1:0] k, input logic [`SRAM_DATA_W-1:0] d);
		o_adv <= v;
		o_write_n <= w;
		o_addr <= a;
		o_lane_n <= l;
		o_cs <= c;
		o_cq_n <= q;
		kn <= k;
		dn <= d;
		@(posedge i_clk);
	endtask : cyc
	// Stages shift on qualified edges only, as the port's pipeline does.
	always @(posedge i_clk) begin
		last <= o_bus;
		if (!o_cq_n) begin
			k1 <= kn;
			d1 <= dn;
			o_kind <= k1;
			o_exp <= d1;
		end
	end
	// Write data is driven in the write's data cycle only; a released bus shows its last level inverted.
	assign o_bus = i_port_oe ? i_port_dq : (o_kind == 2'h1) ? o_exp : ~last;
endmodule : mem_ctrl_model
`default_nettype wire

// ---- test_burst_sram_port.sv ----
// Bench for the burst memory port: pin traffic through the controller model, register bus cycles.
// Assumes the checker binds itself into the port.
`include "burst_sram_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_burst_sram_port;
	logic i_core_clk;
	logic i_nrst;
	logic i_output_enable_n;
	logic i_sleep_request;
	logic i_burst_order_interleave;
	logic i_psel;
	logic i_penable;
	logic i_pwrite;
	logic [`APB_ADDR_W-1:0] i_paddr;
	logic [31:0] i_pwdata;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic [`SRAM_DATA_W-1:0] o_dq;
	logic o_dq_oe;
	logic [`SRAM_ADDR_W-1:0] i_addr;
	logic i_burst_advance_or_load;
	logic i_write_n;
	logic [`SRAM_LANES-1:0] i_byte_lane_write_n;
	logic [2:0] cs;
	logic i_clock_qualify_n;
	logic [`SRAM_DATA_W-1:0] i_dq;
	logic [1:0] kind;
	logic [`SRAM_DATA_W-1:0] want;
	logic [`SRAM_DATA_W-1:0] mem [0:15];
	logic [31:0] r;
	logic e;
	int num_errors = 0;
	int checks_done = 0;
	burst_sram_port burst_sram_port_i (.i_core_clk, .i_nrst, .i_addr, .i_burst_advance_or_load, .i_write_n,
		.i_byte_lane_write_n, .i_chip_select_first_n(cs[2]), .i_chip_select_second(cs[1]),
		.i_chip_select_third_n(cs[0]), .i_clock_qualify_n, .i_output_enable_n, .i_sleep_request,
		.i_burst_order_interleave, .i_dq, .o_dq, .o_dq_oe, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .o_prdata, .o_pready, .o_pslverr);
	mem_ctrl_model mem_ctrl_model_i (.i_clk(i_core_clk), .i_port_dq(o_dq), .i_port_oe(o_dq_oe),
		.o_addr(i_addr), .o_adv(i_burst_advance_or_load), .o_write_n(i_write_n),
		.o_lane_n(i_byte_lane_write_n), .o_cs(cs), .o_cq_n(i_clock_qualify_n), .o_bus(i_dq),
		.o_kind(kind), .o_exp(want));
	function automatic logic [35:0] pat(input int a, input int s);
		return {9'(a + s), 9'(a + s + 9'h55), 9'(a + s + 9'hAA), 9'(a + s + 9'h1F)};
	endfunction : pat
	task automatic check(input string n, input logic [35:0] seen, input logic [35:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wr(input int a, input logic [3:0] ln, input logic [35:0] d);
		for (int k = 0; k < 4; k++) begin
			if (!ln[k]) mem[a][9*k +: 9] = d[9*k +: 9];
		end
		mem_ctrl_model_i.cyc(1'h0, 1'h0, 18'(a), ln, 3'h2, 1'h0, 2'h1, d);
	endtask : wr
	task automatic rd(input int a);
		mem_ctrl_model_i.cyc(1'h0, 1'h1, 18'(a), 4'hF, 3'h2, 1'h0, 2'h2, mem[a]);
	endtask : rd
	task automatic idle();
		mem_ctrl_model_i.cyc(1'h1, 1'h1, 18'h0, 4'hF, 3'h2, 1'h0, 2'h0, 36'h0);
	endtask : idle
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		i_psel <= 1'h1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_core_clk);
		i_penable <= 1'h1;
		do @(posedge i_core_clk); while (o_pready !== 1'h1);
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(posedge i_core_clk);
	endtask : apb
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : conclude
	always @(negedge i_core_clk) begin
		if (i_nrst && kind == 2'h2) begin
			check("rdata", o_dq, want);
			check("rdrive", 36'(o_dq_oe), 36'(!i_output_enable_n));
		end else if (i_nrst && kind != 2'h0) begin
			check("float", 36'(o_dq_oe), 36'h0);
		end
	end
	initial begin
		i_core_clk = 1'h0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	initial begin
		#100000;
		num_errors++;
		conclude();
	end
	initial begin
		{i_nrst, i_output_enable_n, i_sleep_request, i_burst_order_interleave} = 4'h0;
		{i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
		repeat (12) @(posedge i_core_clk);
		check("rst", 36'({o_dq_oe, o_pready}), 36'h0);
		check("rst_dq", o_dq, 36'h0);
		i_nrst <= 1'h1;
		for (int a = 0; a < 16; a++) wr(a, 4'h0, pat(a, 0));
		for (int a = 0; a < 16; a++) rd(a);
		wr(3, 4'hA, pat(3, 'h33));
		rd(3);
		wr(5, 4'h5, pat(5, 'h7));
		rd(5);
		rd(3);
		for (int c = 0; c < 3; c++) begin
			mem_ctrl_model_i.cyc(1'h0, 1'h0, 18'h6, 4'h0, 3'h2 ^ (3'h1 << c), 1'h0, 2'h1, ~mem[6]);
			mem_ctrl_model_i.cyc(1'h0, 1'h1, 18'h6, 4'hF, 3'h2 ^ (3'h1 << c), 1'h0, 2'h3, 36'h0);
			rd(6);
		end
		rd(7);
		rd(9);
		repeat (3) mem_ctrl_model_i.cyc(1'h0, 1'h1, 18'h8, 4'hF, 3'h2, 1'h1, 2'h0, 36'h0);
		idle();
		for (int s = 0; s < 2; s++) begin
			i_burst_order_interleave <= s[0];
			idle();
			for (int k = 0; k < 4; k++)
				mem_ctrl_model_i.cyc(k != 0, 1'h1, 18'h9, 4'hF, 3'h2, 1'h0, 2'h2, mem[s ? 9 ^ k : 8 + ((1 + k) & 3)]);
			idle();
			apb(1'h0, 12'h004, 32'h0);
			check("strap", 36'(r[1]), 36'(s));
		end
		rd(0);
		rd(1);
		rd(2);
		i_output_enable_n <= 1'h1;
		rd(3);
		repeat (2) idle();
		i_output_enable_n <= 1'h0;
		i_sleep_request <= 1'h1;
		idle();
		mem_ctrl_model_i.cyc(1'h0, 1'h0, 18'hA, 4'h0, 3'h2, 1'h0, 2'h1, ~mem[10]);
		mem_ctrl_model_i.cyc(1'h0, 1'h1, 18'hA, 4'hF, 3'h2, 1'h0, 2'h3, 36'h0);
		i_sleep_request <= 1'h0;
		idle();
		rd(10);
		idle();
		idle();
		apb(1'h1, 12'h000, 32'hFFFF_FFFF);
		apb(1'h0, 12'h000, 32'h0);
		check("ctrl", 36'(r), 36'h1);
		apb(1'h0, 12'h004, 32'h0);
		check("asleep", 36'(r[0]), 36'h1);
		apb(1'h1, 12'h000, 32'h0);
		apb(1'h0, 12'h008, 32'h0);
		check("unmapped", 36'({e, r}), 36'h1_0000_0000);
		conclude();
	end
endmodule : test_burst_sram_port
`default_nettype wire
